// ### pkg/eifl_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the external fill error logger
// Assumes: 40-bit register addresses on the internal register read port
// Notes:   the part revision value is arbitrary
//////////////////////////////////////////////////////////////////////////////
package eifl_pkg;
	// register read addresses
	localparam logic [39:0] ADDR_PATTERN = 40'hFFFFF00068;
	localparam logic [39:0] ADDR_ERRADDR = 40'hFFFFF00148;
	localparam logic [39:0] ADDR_STATUS = 40'hFFFFF00168;
	localparam logic [39:0] ADDR_TAGCAP = 40'hFFFFF00108;
	// status field positions
	localparam int ST_ID_LSB = 24;
	localparam int ST_TPE = 28;
	localparam int ST_TCE = 29;
	localparam int ST_ORIGIN = 30;
	localparam int ST_FIX = 31;
	localparam int ST_FATAL = 32;
	localparam int ST_CMD = 33;
	localparam int ST_IREF = 34;
	localparam int ST_REPEAT = 35;
	// capture field positions
	localparam int ADDR_LSB = 4;
	localparam int SYN_LO_LSB = 0;
	localparam int SYN_HI_LSB = 8;
	localparam int TAG_LSB = 12;
	// reset values of the read port
	localparam logic [63:0] RDATA_RST = 64'h0000000000000000;
	// part revision code, value arbitrary
	localparam logic [3:0] PART_REVISION = 4'hA;
	// byte parity sense: 0 even, 1 odd
	localparam logic PAR_ODD = 1'b0;
	// check-bit contribution of each data bit
	localparam logic [7:0] ECC_COL [0:63] = '{
		8'hCE, 8'hCB, 8'hD3, 8'hD5, 8'hD6, 8'hD9, 8'hDA, 8'hDC,
		8'h23, 8'h25, 8'h26, 8'h29, 8'h2A, 8'h2C, 8'h31, 8'h34,
		8'h0E, 8'h0B, 8'h13, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h1C,
		8'hE3, 8'hE5, 8'hE6, 8'hE9, 8'hEA, 8'hEC, 8'hF1, 8'hF4,
		8'h4F, 8'h4A, 8'h52, 8'h54, 8'h57, 8'h58, 8'h5B, 8'h5D,
		8'hA2, 8'hA4, 8'hA7, 8'hA8, 8'hAB, 8'hAD, 8'hB0, 8'hB5,
		8'h8F, 8'h8A, 8'h92, 8'h94, 8'h97, 8'h98, 8'h9B, 8'h9D,
		8'h62, 8'h64, 8'h67, 8'h68, 8'h6B, 8'h6D, 8'h70, 8'h75
	};
endpackage : eifl_pkg

// ### rtl/eifl_logger.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: external interface error logger with status, address, pattern
// Assumes: all event inputs are one-cycle pulses synchronous to i_clk_sys
// Notes:   logged state is not touched by reset; only the read port resets
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] a status read unlocks and clears the logged set, except in the mixed case
// [R2] reset leaves status, capture registers and lock untouched
// [R3] command parity always fatal; fill parity fatal in parity mode
// [R4] only the status read unlocks, or forced-hit entry for the tag snapshot; other reads have no side effect
// [R5] first fixable error loads unlocked; later fixable errors ignored
// [R6] first fatal error loads and locks; then only repeat flag changes
// [R7] repeat flag only on fatal after fatal, never on fixable
// [R8] tag and tag state parity faults count as fatal
// [R9] mixed fixable and fatal on read: clear fixable only, stay locked
// [R10] all other states: read clears every flag and unlocks
// [R11] software repeats the read sequence after seeing the mixed state
// [R12] status bits 27:24 return the fixed part revision code
// [R13] bit 28 tag address parity fault, bit 29 tag state parity fault
// [R14] bit 30 set for memory or command origin, clear for cache fill
// [R15] bit 31 fixable, 32 fatal data, 33 command address parity
// [R16] bit 34 set for instruction refill, clear for data refill
// [R17] bit 35 set on a fatal error while a fatal flag is set
// [R18] address capture holds physical address bits 39:4
// [R19] ECC mode: low quadword syndrome 7:0, high quadword 15:8
// [R20] parity mode: pattern holds per-byte bad parity mask
// [R21] single-bit syndromes follow the fixed check-bit code
// [R22] tag snapshot reloads each tag read unless locked; fault locks it
module eifl_logger (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// register read port
	input wire logic i_ipr_rd,
	input wire logic [39:0] i_ipr_addr,
	output logic [63:0] o_ipr_rdata,
	output logic o_ipr_rvalid,
	// fill data
	input wire logic i_fill_valid,
	input wire logic i_fill_from_mem,
	input wire logic i_fill_iref,
	input wire logic [39:4] i_fill_addr,
	input wire logic [127:0] i_fill_data,
	input wire logic [15:0] i_fill_check,
	input wire logic i_ecc_mode,
	// received system command
	input wire logic i_cmd_par_err,
	input wire logic [39:4] i_cmd_addr,
	// cache tag read
	input wire logic i_tag_rd,
	input wire logic [38:12] i_tag_info,
	input wire logic [39:4] i_tag_addr,
	input wire logic i_tag_addr_par_err,
	input wire logic i_tag_state_par_err,
	input wire logic i_forced_hit_enter
);
	logic rst_meta_q;
	logic rst_q;
	logic fix_q, fatal_q, cmd_q, tpe_q, tce_q, origin_q, iref_q, repeat_q;
	logic lock_q;
	logic [39:4] addr_q;
	logic [15:0] pattern_q;
	logic [15:0] fill_pattern;
	logic [1:0] qw_fix, qw_fatal;
	logic [38:12] tag_snap;
	logic tag_locked;
	logic stat_rd, mixed, hard_held, keep_lock;
	logic ev_fix, ev_data, ev_cmd, ev_tpe, ev_tce, ev_hard;
	logic base_fix, base_hard;
	logic load_hard, load_fix;

	//////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// fill checkers, one per quadword of the octaword
	for (genvar q = 0; q < 2; q++) begin : g_qw
		eifl_qw_check u_chk (
			.i_data(i_fill_data[64*q +: 64]),
			.i_check(i_fill_check[8*q +: 8]),
			.i_ecc_mode(i_ecc_mode),
			.o_pattern(fill_pattern[8*q +: 8]), // R19
			.o_fixable(qw_fix[q]),
			.o_fatal(qw_fatal[q])
		);
	end

	// tag snapshot, opened by a status read or forced-hit entry
	eifl_tag_capture u_tag (
		.i_clk_sys(i_clk_sys),
		.i_tag_rd(i_tag_rd),
		.i_tag_info(i_tag_info),
		.i_tag_fault(i_tag_addr_par_err | i_tag_state_par_err),
		.i_unlock(stat_rd | i_forced_hit_enter), // R22
		.o_snapshot(tag_snap),
		.o_locked(tag_locked)
	);

	//////////////////////////////////////////////////////////////////////////
	// event classification
	always_comb begin
		ev_data = i_fill_valid && (|qw_fatal); // R3
		ev_fix = i_fill_valid && (|qw_fix) && !(|qw_fatal);
		ev_cmd = i_cmd_par_err; // R3
		ev_tpe = i_tag_rd && i_tag_addr_par_err; // R8
		ev_tce = i_tag_rd && i_tag_state_par_err; // R8
		ev_hard = ev_data || ev_cmd || ev_tpe || ev_tce; // R8
	end

	// read side: what the status read leaves behind before new events
	always_comb begin
		stat_rd = i_ipr_rd && (i_ipr_addr == eifl_pkg::ADDR_STATUS); // R4
		hard_held = fatal_q || cmd_q || tpe_q || tce_q;
		mixed = fix_q && hard_held;
		keep_lock = !stat_rd || mixed; // R9
		base_fix = fix_q && !stat_rd; // R1
		base_hard = hard_held && keep_lock; // R10
		// a fatal error loads only when nothing fatal is held
		load_hard = ev_hard && !base_hard; // R6
		// fixable loads only when open and no fixable is held
		load_fix = ev_fix && !ev_hard && !base_hard && !base_fix; // R5
	end

	//////////////////////////////////////////////////////////////////////////
	// hard error flags: never reset, set wins over a read clear
	always_ff @(posedge i_clk_sys) begin // R2
		if (load_hard) begin
			fatal_q <= ev_data; // R15
			cmd_q <= ev_cmd; // R15
			tpe_q <= ev_tpe; // R13
			tce_q <= ev_tce; // R13
		end else if (!keep_lock) begin
			fatal_q <= 1'b0; // R10
			cmd_q <= 1'b0;
			tpe_q <= 1'b0;
			tce_q <= 1'b0;
		end
	end

	// fixable flag; cleared alone in the mixed case
	always_ff @(posedge i_clk_sys) begin
		if (load_fix) fix_q <= 1'b1; // R5
		else if (stat_rd) fix_q <= 1'b0; // R9
	end

	// repeat flag: a fatal error while a fatal flag stays held
	always_ff @(posedge i_clk_sys) begin
		if (ev_hard && base_hard) repeat_q <= 1'b1; // R17
		else if (!keep_lock) repeat_q <= 1'b0; // R7
	end

	// lock follows the fatal flags
	always_ff @(posedge i_clk_sys) begin
		if (load_hard) lock_q <= 1'b1; // R6
		else if (!keep_lock) lock_q <= 1'b0; // R1
	end

	// captured origin, stream, address and pattern; held while locked
	always_ff @(posedge i_clk_sys) begin
		if (load_hard || load_fix) begin
			origin_q <= ev_cmd || i_fill_from_mem; // R14
			iref_q <= i_fill_iref; // R16
			if (ev_cmd) addr_q <= i_cmd_addr; // R18
			else if (ev_data || ev_fix) addr_q <= i_fill_addr; // R18
			else addr_q <= i_tag_addr;
			pattern_q <= (ev_data || ev_fix) ? fill_pattern : 16'h0000; // R20
		end else if (!keep_lock) begin
			// a clearing read empties the whole status image, not only the flags
			origin_q <= 1'b0; // R1
			iref_q <= 1'b0; // R10
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read port: registered data, reads other than status have no effect
	always_ff @(posedge i_clk_sys or negedge rst_q) begin
		if (!rst_q) begin
			o_ipr_rdata <= eifl_pkg::RDATA_RST;
			o_ipr_rvalid <= 1'b0;
		end else begin
			o_ipr_rvalid <= i_ipr_rd;
			o_ipr_rdata <= eifl_pkg::RDATA_RST;
			if (i_ipr_rd) begin
				unique case (i_ipr_addr)
					eifl_pkg::ADDR_STATUS: begin
						o_ipr_rdata[eifl_pkg::ST_ID_LSB +: 4] <= eifl_pkg::PART_REVISION; // R12
						o_ipr_rdata[eifl_pkg::ST_TPE] <= tpe_q; // R13
						o_ipr_rdata[eifl_pkg::ST_TCE] <= tce_q; // R13
						o_ipr_rdata[eifl_pkg::ST_ORIGIN] <= origin_q; // R14
						o_ipr_rdata[eifl_pkg::ST_FIX] <= fix_q; // R15
						o_ipr_rdata[eifl_pkg::ST_FATAL] <= fatal_q; // R15
						o_ipr_rdata[eifl_pkg::ST_CMD] <= cmd_q; // R15
						o_ipr_rdata[eifl_pkg::ST_IREF] <= iref_q; // R16
						o_ipr_rdata[eifl_pkg::ST_REPEAT] <= repeat_q; // R17
					end
					eifl_pkg::ADDR_ERRADDR: begin
						o_ipr_rdata[39:eifl_pkg::ADDR_LSB] <= addr_q; // R18
					end
					eifl_pkg::ADDR_PATTERN: begin
						o_ipr_rdata[eifl_pkg::SYN_LO_LSB +: 16] <= pattern_q; // R19
					end
					eifl_pkg::ADDR_TAGCAP: begin
						o_ipr_rdata[38:eifl_pkg::TAG_LSB] <= tag_snap; // R22
					end
					default: begin
						o_ipr_rdata <= eifl_pkg::RDATA_RST;
					end
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_open_fatal;
		ev_hard && !base_hard;
	endsequence

	sequence s_locked_after;
		##1 lock_q && (addr_q == $past(addr_q, 1));
	endsequence

	property p_fatal_locks;
		@(posedge i_clk_sys) disable iff (!rst_q)
		s_open_fatal |-> ##1 lock_q;
	endproperty
	a_fatal_locks: assert property (p_fatal_locks) else $error("fatal not locked"); // R6

	property p_locked_holds;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(lock_q && !stat_rd) |=> (addr_q == $past(addr_q)) && (pattern_q == $past(pattern_q));
	endproperty
	a_locked_holds: assert property (p_locked_holds) else $error("locked capture moved"); // R6

	property p_mixed_read;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(stat_rd && mixed) |=> lock_q && !fix_q;
	endproperty
	a_mixed_read: assert property (p_mixed_read) else $error("mixed read wrong"); // R9

	property p_plain_read;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(stat_rd && !mixed && !ev_hard && !ev_fix) |=> !lock_q && !fix_q && !fatal_q
			&& !cmd_q && !repeat_q;
	endproperty
	a_plain_read: assert property (p_plain_read) else $error("read did not clear"); // R10

	property p_fix_reload;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(fix_q && !stat_rd && !ev_hard) |=> (addr_q == $past(addr_q)) && !lock_q == !$past(lock_q);
	endproperty
	a_fix_reload: assert property (p_fix_reload) else $error("second fixable reloaded"); // R5

	property p_repeat_cause;
		@(posedge i_clk_sys) disable iff (!rst_q)
		$rose(repeat_q) |-> $past(ev_hard) && $past(hard_held);
	endproperty
	a_repeat_cause: assert property (p_repeat_cause) else $error("repeat without cause"); // R7

	property p_repeat_set;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(ev_hard && hard_held && !stat_rd) |=> repeat_q;
	endproperty
	a_repeat_set: assert property (p_repeat_set) else $error("repeat not set"); // R17

	property p_other_read;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(i_ipr_rd && !stat_rd && lock_q && !ev_hard) |=> lock_q;
	endproperty
	a_other_read: assert property (p_other_read) else $error("side effect on read"); // R4

	property p_status_id;
		@(posedge i_clk_sys) disable iff (!rst_q)
		stat_rd |=> o_ipr_rvalid ##0 (o_ipr_rdata[27:24] == eifl_pkg::PART_REVISION)
			&& (o_ipr_rdata[31] === $past(fix_q));
	endproperty
	a_status_id: assert property (p_status_id) else $error("status read data wrong"); // R12

	property p_cmd_fatal;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(i_cmd_par_err && !base_hard) |=> cmd_q && origin_q ##0 s_locked_after;
	endproperty
	a_cmd_fatal: assert property (p_cmd_fatal) else $error("command parity not fatal"); // R3

	property p_tag_lock;
		@(posedge i_clk_sys) disable iff (!rst_q)
		(i_tag_rd && i_tag_addr_par_err) |=> tag_locked;
	endproperty
	a_tag_lock: assert property (p_tag_lock) else $error("tag fault not locked"); // R22
endmodule : eifl_logger

// ### rtl/eifl_qw_check.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: check one fill quadword, ECC syndrome or byte parity mask
// Assumes: check bits arrive with the data in the same cycle
// Notes:   purely combinational
//////////////////////////////////////////////////////////////////////////////
module eifl_qw_check (
	// quadword and its check bits
	input wire logic [63:0] i_data,
	input wire logic [7:0] i_check,
	input wire logic i_ecc_mode,
	// result
	output logic [7:0] o_pattern,
	output logic o_fixable,
	output logic o_fatal
);
	logic [7:0] calc;
	logic [7:0] syn;
	logic [7:0] bad;
	logic match;

	// syndrome, single-bit match and byte parity
	always_comb begin
		calc = 8'h00;
		bad = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (i_data[i]) calc = calc ^ eifl_pkg::ECC_COL[i]; // R21
		end
		syn = calc ^ i_check;
		match = $onehot(syn); // R21
		for (int i = 0; i < 64; i++) begin
			if (syn == eifl_pkg::ECC_COL[i]) match = 1'b1; // R21
		end
		for (int b = 0; b < 8; b++) begin
			bad[b] = (^i_data[8*b +: 8]) ^ i_check[b] ^ eifl_pkg::PAR_ODD; // R20
		end
		if (i_ecc_mode) begin
			o_pattern = syn; // R19
			o_fixable = (syn != 8'h00) && match;
			o_fatal = (syn != 8'h00) && !match;
		end else begin
			o_pattern = bad; // R20
			o_fixable = 1'b0;
			o_fatal = |bad; // R3
		end
	end
endmodule : eifl_qw_check

// ### rtl/eifl_tag_capture.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: cache tag snapshot with its own lock
// Assumes: one tag read result per cycle at most
// Notes:   contents and lock deliberately survive reset
//////////////////////////////////////////////////////////////////////////////
module eifl_tag_capture (
	// clock
	input wire logic i_clk_sys,
	// tag read result
	input wire logic i_tag_rd,
	input wire logic [38:12] i_tag_info,
	input wire logic i_tag_fault,
	// unlock sources
	input wire logic i_unlock,
	// snapshot
	output logic [38:12] o_snapshot,
	output logic o_locked
);
	logic lock_q;
	logic [38:12] snap_q;

	// reload on every tag read while open; no reset on purpose
	always_ff @(posedge i_clk_sys) begin
		if ((!lock_q || i_unlock) && i_tag_rd) snap_q <= i_tag_info; // R22
	end

	// a tag fault locks, the unlock loses to a fault in the same cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_tag_rd && i_tag_fault && (!lock_q || i_unlock)) lock_q <= 1'b1; // R22
		else if (i_unlock) lock_q <= 1'b0; // R22
	end

	assign o_snapshot = snap_q;
	assign o_locked = lock_q;
endmodule : eifl_tag_capture

// ### verification/eifl_fill_source.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: far-side model supplying fill octawords with their check bits
// Assumes: the bench drives its request just after a rising edge
// Notes:   flip masks inject data or check bit faults on purpose
//////////////////////////////////////////////////////////////////////////////
module eifl_fill_source (
	// request from the bench
	input wire logic i_send,
	input wire logic i_ecc_mode,
	input wire logic [127:0] i_data,
	input wire logic [127:0] i_data_flip,
	input wire logic [15:0] i_chk_flip,
	// fill towards the logger
	output logic o_fill_valid,
	output logic [127:0] o_fill_data,
	output logic [15:0] o_fill_check
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] good;
	//////////////////////////////////////////////////////////////////////////
	// clean check bits: code per quadword, or byte parity in parity mode
	always_comb begin
		good = 16'h0000;
		for (int q = 0; q < 2; q++) begin
			for (int i = 0; i < 64; i++) begin
				if (i_ecc_mode && i_data[q*64+i]) begin
					good[q*8 +: 8] = good[q*8 +: 8] ^ eifl_pkg::ECC_COL[i];
				end
			end
			for (int b = 0; b < 8; b++) begin
				if (!i_ecc_mode) begin
					good[q*8+b] = (^i_data[q*64+b*8 +: 8]) ^ eifl_pkg::PAR_ODD;
				end
			end
		end
	end
	// released lines show the inverse, so stale data never looks valid
	assign o_fill_valid = i_send;
	assign o_fill_data = i_send ? (i_data ^ i_data_flip) : ~i_data;
	assign o_fill_check = i_send ? (good ^ i_chk_flip) : ~good;
endmodule : eifl_fill_source

// ### verification/ext_fill_error_logger_test.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the external fill error logger
// Assumes: logged state is unknown at power-up until two status reads
// Notes:   origin and refill bits are masked for tag faults, undefined there
//////////////////////////////////////////////////////////////////////////////
module ext_fill_error_logger_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [127:0] DAT = 128'h0123456789ABCDEFFEDCBA9876543210;
	localparam logic [63:0] UNDEF = 64'h0000000440000000;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rd = 1'b0;
	logic send = 1'b0;
	logic mem = 1'b0;
	logic iref = 1'b0;
	logic ecc = 1'b1;
	logic cmd = 1'b0;
	logic tagrd = 1'b0;
	logic tpe = 1'b0;
	logic tce = 1'b0;
	logic fhit = 1'b0;
	logic [39:0] addr = '0;
	logic [39:4] faddr = '0;
	logic [39:4] caddr = '0;
	logic [39:4] taddr = '0;
	logic [38:12] tinfo = '0;
	logic [127:0] dflip = '0;
	logic [15:0] cflip = '0;
	logic [63:0] rdata;
	logic [63:0] v;
	logic rvalid;
	logic fvalid;
	logic [127:0] fdata;
	logic [15:0] fchk;
	int fail_count = 0;
	int total_checks = 0;
	//////////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	always #2.5 clk = ~clk;
	eifl_fill_source u_src (.i_send(send), .i_ecc_mode(ecc), .i_data(DAT), .i_data_flip(dflip),
		.i_chk_flip(cflip), .o_fill_valid(fvalid), .o_fill_data(fdata), .o_fill_check(fchk));
	eifl_logger u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_ipr_rd(rd), .i_ipr_addr(addr),
		.o_ipr_rdata(rdata), .o_ipr_rvalid(rvalid), .i_fill_valid(fvalid),
		.i_fill_from_mem(mem), .i_fill_iref(iref), .i_fill_addr(faddr), .i_fill_data(fdata),
		.i_fill_check(fchk), .i_ecc_mode(ecc), .i_cmd_par_err(cmd), .i_cmd_addr(caddr),
		.i_tag_rd(tagrd), .i_tag_info(tinfo), .i_tag_addr(taddr), .i_tag_addr_par_err(tpe),
		.i_tag_state_par_err(tce), .i_forced_hit_enter(fhit));
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// status image: f = repeat,iref,cmd,fatal,fix,origin,tce,tpe
	function automatic logic [63:0] st(input logic [7:0] f);
		st = 64'h0000000000000000;
		st[27:24] = eifl_pkg::PART_REVISION;
		st[35:28] = f;
	endfunction : st
	function automatic logic [63:0] ea(input logic [39:4] a);
		ea = {24'h000000, a, 4'h0};
	endfunction : ea
	// one read, answer taken the cycle after the request
	task automatic rd_reg(input logic [39:0] a, output logic [63:0] d);
		@(posedge clk);
		#1 rd = 1'b1;
		addr = a;
		@(posedge clk);
		#1 rd = 1'b0;
		chk("rvalid", {63'h0, rvalid}, 64'h1);
		d = rdata;
	endtask : rd_reg
	task automatic look(input logic [39:0] a, input logic [63:0] exp, input string what);
		logic [63:0] d;
		rd_reg(a, d);
		chk(what, d, exp);
	endtask : look
	task automatic fill(input logic m, input logic ir, input logic [39:4] a,
		input logic [127:0] df, input logic [15:0] cf);
		@(posedge clk);
		#1 send = 1'b1;
		mem = m;
		iref = ir;
		faddr = a;
		dflip = df;
		cflip = cf;
		@(posedge clk);
		#1 send = 1'b0;
		iref = 1'b0;
	endtask : fill
	task automatic tag(input logic [38:12] ti, input logic [39:4] a, input logic ap,
		input logic sp);
		@(posedge clk);
		#1 tagrd = 1'b1;
		tinfo = ti;
		taddr = a;
		tpe = ap;
		tce = sp;
		@(posedge clk);
		#1 tagrd = 1'b0;
		tpe = 1'b0;
		tce = 1'b0;
	endtask : tag
	task automatic do_reset();
		@(posedge clk);
		#1 rstn = 1'b0;
		repeat (5) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (2) @(posedge clk);
	endtask : do_reset
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	//////////////////////////////////////////////////////////////////////////
	// watchdog, far beyond the hundred or so cycles the sequence needs
	initial begin
		#20000;
		fail_count++;
		test_done();
	end
	// main sequence
	initial begin
		do_reset();
		rd_reg(eifl_pkg::ADDR_STATUS, v);
		rd_reg(eifl_pkg::ADDR_STATUS, v);
		look(eifl_pkg::ADDR_STATUS, st(8'h00), "status idle");
		look(40'hFFFFF00000, 64'h0, "unmapped");
		// fixable, reset, second fixable ignored
		fill(1'b0, 1'b1, 36'h123456789, 128'h1, 16'h0000);
		do_reset();
		fill(1'b1, 1'b0, 36'h000000ABC, 128'h0, 16'h8000);
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h123456789), "address");
		look(eifl_pkg::ADDR_PATTERN, 64'h00CE, "pattern");
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h123456789), "address again");
		look(eifl_pkg::ADDR_STATUS, st(8'h48), "status fixable");
		look(eifl_pkg::ADDR_STATUS, st(8'h00), "status cleared");
		// fixable then fatal: mixed state
		fill(1'b0, 1'b0, 36'h000000111, 128'h20, 16'h0000);
		fill(1'b1, 1'b0, 36'h000000222, 128'h3, 16'h0000);
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h000000222), "address fatal");
		look(eifl_pkg::ADDR_PATTERN, 64'h0005, "pattern fatal");
		look(eifl_pkg::ADDR_STATUS, st(8'h1C), "status mixed");
		fill(1'b0, 1'b0, 36'h000000333, 128'h1, 16'h0000);
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h000000222), "address locked");
		look(eifl_pkg::ADDR_STATUS, st(8'h14), "status after mixed");
		look(eifl_pkg::ADDR_STATUS, st(8'h00), "status cleared 2");
		// command parity then parity-mode fill: repeat only
		@(posedge clk);
		#1 cmd = 1'b1;
		caddr = 36'h000000444;
		ecc = 1'b0;
		@(posedge clk);
		#1 cmd = 1'b0;
		fill(1'b0, 1'b0, 36'h000000555, 128'h100, 16'h0000);
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h000000444), "address cmd");
		look(eifl_pkg::ADDR_STATUS, st(8'hA4), "status repeat");
		look(eifl_pkg::ADDR_STATUS, st(8'h00), "status cleared 3");
		// parity-mode fill: byte mask
		fill(1'b0, 1'b1, 36'h000000666, {1'b1, 63'h0, 64'h100}, 16'h0000);
		look(eifl_pkg::ADDR_PATTERN, 64'h8002, "pattern parity");
		look(eifl_pkg::ADDR_STATUS, st(8'h50), "status parity");
		ecc = 1'b1;
		// tag snapshot, tag faults lock it
		tag(27'h1234567, 36'h000000777, 1'b0, 1'b0);
		look(eifl_pkg::ADDR_TAGCAP, {25'h0, 27'h1234567, 12'h0}, "tag snapshot");
		tag(27'h0ABCDEF, 36'h000000888, 1'b1, 1'b0);
		tag(27'h7654321, 36'h000000999, 1'b0, 1'b0);
		tag(27'h5555555, 36'h000000AAA, 1'b0, 1'b1);
		look(eifl_pkg::ADDR_TAGCAP, {25'h0, 27'h0ABCDEF, 12'h0}, "tag locked");
		look(eifl_pkg::ADDR_ERRADDR, ea(36'h000000888), "address tag");
		rd_reg(eifl_pkg::ADDR_STATUS, v);
		chk("status tag", v & ~UNDEF, st(8'h81));
		// tag state fault, then forced-hit entry unlocks the snapshot
		tag(27'h0000111, 36'h000000BBB, 1'b0, 1'b1);
		@(posedge clk);
		#1 fhit = 1'b1;
		@(posedge clk);
		#1 fhit = 1'b0;
		tag(27'h0000222, 36'h000000CCC, 1'b0, 1'b0);
		look(eifl_pkg::ADDR_TAGCAP, {25'h0, 27'h0000222, 12'h0}, "tag unlocked");
		rd_reg(eifl_pkg::ADDR_STATUS, v);
		chk("status tag state", v & ~UNDEF, st(8'h02));
		test_done();
	end
endmodule : ext_fill_error_logger_test
